/* design/acr_converter_control.sv */
// Purpose: Control, sequencing and result registers of a 10-bit converter
// Assumes: Analog front end delivers the finished code on analogCode
// Notes:   Differential codes arrive offset binary and leave two's complement
`timescale 1ns/100ps
module acr_converter_control (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic [3:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [3:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic [9:0]             analogCode,
   input  wire logic                   vectorAck,
   output logic                        conversionIrq,
   output logic                        converterOn,
   output logic                        sampleActive,
   output logic [1:0]                  referenceSelect,
   output logic                        internalRefOn,
   output logic [2:0]                  posInput,
   output logic [2:0]                  negInput,
   output acr_pkg::acr_gain_type       gainSelect,
   output logic                        diffMode,
   output logic                        bandgapSelect,
   output logic                        groundSelect
);
   // ****************************************
   // Declarations
   // ****************************************
   acr_pkg::acr_state_type state_reg;
   acr_pkg::acr_gain_type  decGain;
   logic [7:0]  muxSelect_reg;
   logic        autoTrig_reg, irqEnable_reg, doneFlag_reg, firstPending_reg, convFirst_reg;
   logic [2:0]  divSel_reg, divShift;
   logic [6:0]  prescale_reg, divLimit;
   logic [4:0]  convTicks_reg, convLen;
   logic [6:0]  activeSel_reg;
   logic [9:0]  result_reg, codeSync1_reg, codeSync2_reg;
   logic        freeze_reg;
   logic        awHeld_reg, wHeld_reg;
   logic [3:0]  awAddr_reg;
   logic [7:0]  wByte_reg;
   logic        wLane_reg;
   logic        doWrite, doRead, ctlWrite, muxWrite, tick, complete, startConv, busy;
   logic [7:0]  wrCtl, resLow, resHigh, ctlRead;
   logic [2:0]  decPos, decNeg;
   logic        decDiff, decBandgap, decGround;

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   // Address and data taken in either order, response after both
   assign s_axi_awready = ~awHeld_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld_reg & ~s_axi_bvalid;
   assign doWrite       = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
   assign wrCtl         = wByte_reg;
   assign ctlWrite      = doWrite & wLane_reg & (awAddr_reg == acr_pkg::ADDR_CONTROL_A);
   assign muxWrite      = doWrite & wLane_reg & (awAddr_reg == acr_pkg::ADDR_MUX_SELECT);

   // Hold the address until the write fires
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         awHeld_reg <= 1'b0;
         awAddr_reg <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_reg <= 1'b1;
         awAddr_reg <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld_reg <= 1'b0;
      end
   end

   // Hold the low data byte and its strobe until the write fires
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wHeld_reg <= 1'b0;
         wByte_reg <= 8'h00;
         wLane_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_reg <= 1'b1;
         wByte_reg <= s_axi_wdata[7:0];
         wLane_reg <= s_axi_wstrb[0];
      end else if (doWrite) begin
         wHeld_reg <= 1'b0;
      end
   end

   // Write response, error for unmapped or read-only words
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= acr_pkg::RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awAddr_reg == acr_pkg::ADDR_CONTROL_A || awAddr_reg == acr_pkg::ADDR_MUX_SELECT)
                         ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   assign s_axi_arready = ~s_axi_rvalid;
   assign doRead        = s_axi_arvalid & s_axi_arready;
   // Alignment applied at read time so a flip shows at once
   assign resLow  = muxSelect_reg[acr_pkg::LADJ_BIT] ? {result_reg[1:0], 6'h00} : result_reg[7:0];
   assign resHigh = muxSelect_reg[acr_pkg::LADJ_BIT] ? result_reg[9:2] : {6'h00, result_reg[9:8]};
   assign ctlRead = {converterOn, busy, autoTrig_reg, doneFlag_reg, irqEnable_reg, divSel_reg};

   // Read data and response
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= acr_pkg::RESP_OKAY;
      end else if (doRead) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= acr_pkg::RESP_OKAY;
         case (s_axi_araddr)
            acr_pkg::ADDR_MUX_SELECT:  s_axi_rdata <= {24'h00_0000, muxSelect_reg};
            acr_pkg::ADDR_CONTROL_A:   s_axi_rdata <= {24'h00_0000, ctlRead};
            acr_pkg::ADDR_RESULT_LOW:  s_axi_rdata <= {24'h00_0000, resLow};
            acr_pkg::ADDR_RESULT_HIGH: s_axi_rdata <= {24'h00_0000, resHigh};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= acr_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   // Selection register, written at any time
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         muxSelect_reg <= acr_pkg::RESET_MUX_SELECT;
      end else if (muxWrite) begin
         muxSelect_reg <= wrCtl;
      end
   end

   // Plain control fields of register A
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         autoTrig_reg  <= acr_pkg::RESET_CONTROL_A[acr_pkg::ATE_BIT];
         irqEnable_reg <= acr_pkg::RESET_CONTROL_A[acr_pkg::IE_BIT];
         divSel_reg    <= acr_pkg::RESET_CONTROL_A[acr_pkg::DIV_MSB:0];
      end else if (ctlWrite) begin
         autoTrig_reg  <= wrCtl[acr_pkg::ATE_BIT];
         irqEnable_reg <= wrCtl[acr_pkg::IE_BIT];
         divSel_reg    <= wrCtl[acr_pkg::DIV_MSB:0];
      end
   end

   // Done flag: completion beats a same-cycle clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         doneFlag_reg <= 1'b0;
      end else if (complete) begin
         doneFlag_reg <= 1'b1;
      end else if (vectorAck || (ctlWrite && wrCtl[acr_pkg::FLAG_BIT])) begin
         doneFlag_reg <= 1'b0;
      end
   end
   assign conversionIrq = doneFlag_reg & irqEnable_reg;

   // ****************************************
   // Conversion sequencer
   // ****************************************
   assign busy        = (state_reg == acr_pkg::ST_CONVERT);
   assign converterOn = (state_reg != acr_pkg::ST_OFF);
   assign sampleActive = busy;
   // Start needs enable in the same write; writing zero to start is ignored
   assign startConv = (ctlWrite && wrCtl[acr_pkg::START_BIT] && wrCtl[acr_pkg::EN_BIT] && !busy)
                      || (complete && autoTrig_reg && !(ctlWrite && !wrCtl[acr_pkg::EN_BIT]));
   // Divider of 2 for codes 0 and 1, else two to the code
   assign divShift = (divSel_reg == 3'h0) ? 3'h1 : divSel_reg;
   assign divLimit = 7'((8'h01 << divShift) - 8'h01);
   assign tick     = busy && (prescale_reg == divLimit);
   assign convLen  = convFirst_reg ? acr_pkg::CONV_CLOCKS_FIRST : acr_pkg::CONV_CLOCKS_NORMAL;
   assign complete = tick && (convTicks_reg == 5'(convLen - 5'h01)) && !(ctlWrite && !wrCtl[acr_pkg::EN_BIT]);

   // Power state and conversion state
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= acr_pkg::ST_OFF;
      end else begin
         case (state_reg)
            acr_pkg::ST_OFF: begin
               if (startConv) begin
                  state_reg <= acr_pkg::ST_CONVERT;
               end else if (ctlWrite && wrCtl[acr_pkg::EN_BIT]) begin
                  state_reg <= acr_pkg::ST_IDLE;
               end
            end
            acr_pkg::ST_IDLE: begin
               if (ctlWrite && !wrCtl[acr_pkg::EN_BIT]) begin
                  state_reg <= acr_pkg::ST_OFF;
               end else if (startConv) begin
                  state_reg <= acr_pkg::ST_CONVERT;
               end
            end
            acr_pkg::ST_CONVERT: begin
               if (ctlWrite && !wrCtl[acr_pkg::EN_BIT]) begin
                  state_reg <= acr_pkg::ST_OFF;
               end else if (complete && !startConv) begin
                  state_reg <= acr_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= acr_pkg::ST_OFF;
            end
         endcase
      end
   end

   // First conversion after enabling is the long one
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         firstPending_reg <= 1'b1;
         convFirst_reg    <= 1'b0;
      end else if (startConv) begin
         firstPending_reg <= 1'b0;
         convFirst_reg    <= firstPending_reg | (state_reg == acr_pkg::ST_OFF);
      end else if (state_reg == acr_pkg::ST_OFF) begin
         firstPending_reg <= 1'b1;
      end
   end

   // Prescaler and converter clock count, restarted per conversion
   always_ff @(posedge clk) begin
      if (!rst_b || startConv || !busy) begin
         prescale_reg  <= 7'h00;
         convTicks_reg <= 5'h00;
      end else if (tick) begin
         prescale_reg  <= 7'h00;
         convTicks_reg <= 5'(convTicks_reg + 5'h01);
      end else begin
         prescale_reg  <= 7'(prescale_reg + 7'h01);
      end
   end

   // Applied selection follows software only between conversions
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         activeSel_reg <= 7'h00;
      end else if (!busy) begin
         activeSel_reg <= {muxSelect_reg[acr_pkg::REF_MSB:acr_pkg::REF_LSB], muxSelect_reg[acr_pkg::CHAN_MSB:0]};
      end
   end

   // ****************************************
   // Analog side selection outputs
   // ****************************************
   acr_channel_decode u_decode (
      .chanCode    (activeSel_reg[4:0]),
      .posInput    (decPos),
      .negInput    (decNeg),
      .gain        (decGain),
      .diffMode    (decDiff),
      .bandgapSel  (decBandgap),
      .groundSel   (decGround),
      .reservedSel ()
   );

   // Registered drive of the analog multiplexer and reference
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         referenceSelect <= acr_pkg::REF_EXTERNAL;
         internalRefOn   <= 1'b0;
         posInput        <= 3'h0;
         negInput        <= 3'h0;
         gainSelect      <= acr_pkg::GAIN_1;
         diffMode        <= 1'b0;
         bandgapSelect   <= 1'b0;
         groundSelect    <= 1'b0;
      end else begin
         referenceSelect <= activeSel_reg[6:5];
         internalRefOn   <= (activeSel_reg[6:5] == acr_pkg::REF_INTERNAL);
         posInput        <= decPos;
         negInput        <= decNeg;
         gainSelect      <= decGain;
         diffMode        <= decDiff;
         bandgapSelect   <= decBandgap;
         groundSelect    <= decGround;
      end
   end

   // ****************************************
   // Result capture
   // ****************************************
   // Code from the analog side passes two flops
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         codeSync1_reg <= 10'h000;
         codeSync2_reg <= 10'h000;
      end else begin
         codeSync1_reg <= analogCode;
         codeSync2_reg <= codeSync1_reg;
      end
   end

   // Low byte read freezes the pair until the high byte is read
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         freeze_reg <= 1'b0;
      end else if (doRead && s_axi_araddr == acr_pkg::ADDR_RESULT_LOW) begin
         freeze_reg <= 1'b1;
      end else if (doRead && s_axi_araddr == acr_pkg::ADDR_RESULT_HIGH) begin
         freeze_reg <= 1'b0;
      end
   end

   // Result lands with the flag unless frozen; differential made two's complement
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         result_reg <= 10'h000;
      end else if (complete && !freeze_reg) begin
         result_reg <= decDiff ? {~codeSync2_reg[acr_pkg::SIGN_BIT], codeSync2_reg[8:0]}
                               : codeSync2_reg;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence seqDone;
      complete && !freeze_reg;
   endsequence
   sequence seqDiffDone;
      seqDone and decDiff;
   endsequence

   AST_FLAG_SET: assert property (complete |=> doneFlag_reg)
      else $error("done flag not set after completion");
   AST_DIFF_SIGN: assert property (seqDiffDone |=> result_reg[9] == ~$past(codeSync2_reg[9]))
      else $error("differential sign bit wrong");
   AST_SE_CODE: assert property ((seqDone and !decDiff) |=> result_reg == $past(codeSync2_reg))
      else $error("single-ended code altered");
   AST_FREEZE: assert property (freeze_reg && !doRead |=> $stable(result_reg))
      else $error("result changed while frozen");
   AST_ABORT: assert property (busy && ctlWrite && !wrCtl[acr_pkg::EN_BIT] |=> !busy && !$rose(doneFlag_reg))
      else $error("conversion not aborted");
   AST_HOLD_SEL: assert property (busy && $past(busy) |-> $stable(activeSel_reg))
      else $error("selection changed mid conversion");
   AST_BUSY_END: assert property (complete && !autoTrig_reg |=> !busy)
      else $error("start bit still set after completion");
   AST_LEFT_HIGH: assert property (muxSelect_reg[5] |-> resHigh == result_reg[9:2] && resLow[5:0] == 6'h00)
      else $error("left adjusted layout wrong");
   AST_RESET: assert property ($rose(rst_b) |-> muxSelect_reg == 8'h00 && !converterOn && !doneFlag_reg)
      else $error("control fields not cleared by reset");
   AST_ENABLE: assert property (ctlWrite && wrCtl[7] |=> converterOn)
      else $error("enable write did not switch on");
   AST_INT_REF: assert property (activeSel_reg[6:5] == 2'h3 |=> internalRefOn)
      else $error("internal reference not switched on");
endmodule // acr_converter_control

/* design/acr_pkg.sv */
// Purpose: Shared constants for the converter control and result block
// Assumes: 8-bit registers, one per aligned 32-bit word on AXI4-Lite
// Notes:   Functional notes below list the behaviour kept by the design
//
// Functional notes
// - Single-ended result is unsigned 0x000 to 0x3FF
// - Single-ended code comes from analog front end
// - Differential code scaled by gain in front end
// - Differential result presented in two's complement
// - Result bit 9 is sign of differential
// - Result valid when done flag rises, unless frozen by a low byte read
// - Reference/channel changes wait for conversion end
// - Reference select decodes external, supply, reserved, internal
// - Left adjust reformats result immediately
// - Codes 0-7 single-ended, bandgap, ground
// - Gain 10/200 differential pairs and shorts
// - Unity gain pairs against input 1, 2
// - Enable bit switches converter on/off
// - Clearing enable aborts running conversion
// - High/low byte layout per alignment
// - Low byte read freezes result until high
// - Start reads busy; first conversion 25 clocks
// - Flag set on completion, cleared by ack/write-one
package acr_pkg;
   // ****************************************
   // Register byte addresses
   // ****************************************
   localparam logic [3:0] ADDR_MUX_SELECT  = 4'h0;
   localparam logic [3:0] ADDR_CONTROL_A   = 4'h4;
   localparam logic [3:0] ADDR_RESULT_LOW  = 4'h8;
   localparam logic [3:0] ADDR_RESULT_HIGH = 4'hC;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int REF_MSB   = 7;
   localparam int REF_LSB   = 6;
   localparam int LADJ_BIT  = 5;
   localparam int CHAN_MSB  = 4;
   localparam int EN_BIT    = 7;
   localparam int START_BIT = 6;
   localparam int ATE_BIT   = 5;
   localparam int FLAG_BIT  = 4;
   localparam int IE_BIT    = 3;
   localparam int DIV_MSB   = 2;
   localparam int SIGN_BIT  = 9;
   // ****************************************
   // Reset values, codes and timing counts
   // ****************************************
   localparam logic [7:0] RESET_MUX_SELECT = 8'h00;
   localparam logic [7:0] RESET_CONTROL_A  = 8'h00;
   localparam logic [4:0] CONV_CLOCKS_NORMAL = 5'h0D;
   localparam logic [4:0] CONV_CLOCKS_FIRST  = 5'h19;
   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [1:0] REF_SUPPLY   = 2'h1;
   localparam logic [1:0] REF_RESERVED = 2'h2;
   localparam logic [1:0] REF_INTERNAL = 2'h3;
   localparam logic [4:0] CH_RESERVED  = 5'h0C;
   localparam logic [4:0] CH_BANDGAP   = 5'h1E;
   localparam logic [4:0] CH_GROUND    = 5'h1F;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   typedef enum logic [1:0] {GAIN_1, GAIN_10, GAIN_200} acr_gain_type;
   typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_CONVERT} acr_state_type;
endpackage

/* design/acr_channel_decode.sv */
// Purpose: Decode of the five-bit channel and gain code
// Assumes: Purely combinational, driven from the applied selection
// Notes:   Shorted pairs report equal positive and negative inputs
`timescale 1ns/100ps
module acr_channel_decode (
   input  wire logic [4:0]           chanCode,
   output logic [2:0]                posInput,
   output logic [2:0]                negInput,
   output acr_pkg::acr_gain_type     gain,
   output logic                      diffMode,
   output logic                      bandgapSel,
   output logic                      groundSel,
   output logic                      reservedSel
);
   // ****************************************
   // Code table
   // ****************************************
   // Split by top two bits of the code
   always_comb begin
      posInput    = chanCode[2:0];
      negInput    = 3'h0;
      gain        = acr_pkg::GAIN_1;
      diffMode    = 1'b0;
      bandgapSel  = 1'b0;
      groundSel   = 1'b0;
      reservedSel = (chanCode == acr_pkg::CH_RESERVED);
      case (chanCode[4:3])
         2'h0: begin
            diffMode = 1'b0;
         end
         2'h1: begin
            // Pairs 1-0 and 3-2, gain from bit 1
            negInput = {1'b0, chanCode[2], 1'b0};
            posInput = {1'b0, chanCode[2], chanCode[0]};
            gain     = chanCode[1] ? acr_pkg::GAIN_200 : acr_pkg::GAIN_10;
            diffMode = 1'b1;
         end
         2'h2: begin
            negInput = 3'h1;
            diffMode = 1'b1;
         end
         default: begin
            if (chanCode == acr_pkg::CH_BANDGAP) begin
               bandgapSel = 1'b1;
            end else if (chanCode == acr_pkg::CH_GROUND) begin
               groundSel = 1'b1;
            end else begin
               negInput = 3'h2;
               diffMode = 1'b1;
            end
         end
      endcase
   end
endmodule // acr_channel_decode

/* bench/acr_front_end_model.sv */
// Purpose: Behavioural analog front end that hands finished codes to the block
// Assumes: Codes follow the applied selection with no settling delay
// Notes:   Differential codes leave here offset binary around 0x200
`timescale 1ns/100ps
module acr_front_end_model #(
   parameter logic [9:0] BANDGAP_CODE = 10'h1B8 // Arbitrary stand-in level
) (
   input  wire logic [1:0]            referenceSelect, // No outside source on the pin
   input  wire logic [2:0]            posInput,
   input  wire logic [2:0]            negInput,
   input  wire acr_pkg::acr_gain_type gainSelect,
   input  wire logic                  diffMode,
   input  wire logic                  bandgapSelect,
   input  wire logic                  groundSelect,
   output logic [9:0]                 analogCode
);
   // ****************************************
   // Code generation
   // ****************************************
   // Differential step of 4 codes per input at unity gain, 40 at higher gain
   always_comb begin
      if (groundSelect) begin
         analogCode = 10'h000;
      end else if (bandgapSelect) begin
         analogCode = BANDGAP_CODE;
      end else if (diffMode) begin
         analogCode = 10'h200 + 10'((int'(posInput) - int'(negInput)) *
                      (gainSelect == acr_pkg::GAIN_1 ? 4 : 40));
      end else begin
         analogCode = {posInput, 7'h15};
      end
   end
endmodule // acr_front_end_model

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: AXI4-Lite master tasks; divider 0 gives 2 system clocks per step
// Notes:   Expected codes derive from the front end model's fixed levels
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
   $display("CHECK FAILED t=%0t got %h want %h", $time, a, e); end end
module tb_top;
   logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, refSel, rsp;
   logic [9:0] analogCode;
   logic vectorAck, irq, convOn, busy, intRef, diffMode, bgSel, gndSel;
   logic [2:0] posIn, negIn;
   logic [7:0] dat, hi;
   acr_pkg::acr_gain_type gainSel;
   int failures, check_count;
   acr_converter_control i_acr_converter_control (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .analogCode(analogCode), .vectorAck(vectorAck), .conversionIrq(irq), .converterOn(convOn),
      .sampleActive(busy), .referenceSelect(refSel), .internalRefOn(intRef), .posInput(posIn),
      .negInput(negIn), .gainSelect(gainSel), .diffMode(diffMode), .bandgapSelect(bgSel),
      .groundSelect(gndSel));
   acr_front_end_model i_acr_front_end_model (.referenceSelect(refSel), .posInput(posIn),
      .negInput(negIn), .gainSelect(gainSel), .diffMode(diffMode), .bandgapSelect(bgSel),
      .groundSelect(gndSel), .analogCode(analogCode));
   // Clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic finish_test();
      $display("Checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      int n;
      awaddr <= a; wdata <= {24'h00_0000, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rsp = bresp;
      bready <= 1'b0;
      if (n == 100) begin failures++; finish_test(); end
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a);
      int n;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      dat = rdata[7:0]; rsp = rresp;
      rready <= 1'b0;
      if (n == 100) begin failures++; finish_test(); end
      @(posedge clk);
   endtask
   // Poll the start bit until the conversion ends
   task automatic wait_done();
      int n;
      for (n = 0; n < 200; n++) begin
         rd(acr_pkg::ADDR_CONTROL_A);
         if (dat[6] === 1'b0) break;
      end
      if (n == 200) begin failures++; finish_test(); end
   endtask
   // Convert one selection and compare both result bytes
   task automatic conv(input logic [7:0] mux, input logic [7:0] eh, input logic [7:0] el);
      wr(acr_pkg::ADDR_MUX_SELECT, mux);
      wr(acr_pkg::ADDR_CONTROL_A, 8'h00C8);
      wait_done();
      `CHK(dat[4], 1'b1)
      `CHK(irq, 1'b1)
      rd(acr_pkg::ADDR_RESULT_LOW);
      `CHK(dat, el)
      rd(acr_pkg::ADDR_RESULT_HIGH);
      `CHK(dat, eh)
      wr(acr_pkg::ADDR_CONTROL_A, 8'h0098);
      `CHK(irq, 1'b0)
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, vectorAck, failures, check_count} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      rst_b = 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(acr_pkg::ADDR_MUX_SELECT);
      `CHK(dat, 8'h00)
      rd(acr_pkg::ADDR_CONTROL_A);
      `CHK(dat, 8'h00)
      wr(acr_pkg::ADDR_MUX_SELECT, 8'h000D);
      repeat (3) @(posedge clk);
      `CHK({posIn, negIn, gainSel, diffMode}, {3'h3, 3'h2, acr_pkg::GAIN_10, 1'b1})
      wr(acr_pkg::ADDR_MUX_SELECT, 8'h001C);
      repeat (3) @(posedge clk);
      `CHK({posIn, negIn, gainSel, diffMode}, {3'h4, 3'h2, acr_pkg::GAIN_1, 1'b1})
      wr(acr_pkg::ADDR_MUX_SELECT, 8'h001F);
      repeat (3) @(posedge clk);
      `CHK(gndSel, 1'b1)
      wr(acr_pkg::ADDR_MUX_SELECT, 8'h1E);
      repeat (3) @(posedge clk);
      `CHK(bgSel, 1'b1)
      `CHK(diffMode, 1'b0)
      conv(8'h0003, 8'h01, 8'h95);
      conv(8'h0023, 8'h65, 8'h40);
      conv(8'h0018, 8'h03, 8'hF8);
      conv(8'h00CD, 8'h00, 8'h28);
      `CHK(refSel, acr_pkg::REF_INTERNAL)
      `CHK(intRef, 1'b1)
      wr(acr_pkg::ADDR_MUX_SELECT, 8'h00ED);
      rd(acr_pkg::ADDR_RESULT_LOW);
      `CHK(dat, 8'h00)
      rd(acr_pkg::ADDR_RESULT_HIGH);
      `CHK(dat, 8'h0A)
      wr(acr_pkg::ADDR_MUX_SELECT, 8'h0018);
      wr(acr_pkg::ADDR_CONTROL_A, 8'h00C0);
      wr(acr_pkg::ADDR_MUX_SELECT, 8'h0058);
      `CHK(refSel, acr_pkg::REF_EXTERNAL)
      `CHK(busy, 1'b1)
      wait_done();
      repeat (3) @(posedge clk);
      `CHK(refSel, acr_pkg::REF_SUPPLY)
      vectorAck <= 1'b1;
      @(posedge clk);
      vectorAck <= 1'b0;
      rd(acr_pkg::ADDR_CONTROL_A);
      `CHK(dat, 8'h80)
      wr(acr_pkg::ADDR_CONTROL_A, 8'h00C0);
      wr(acr_pkg::ADDR_CONTROL_A, 8'h0000);
      rd(acr_pkg::ADDR_CONTROL_A);
      `CHK(dat, 8'h00)
      `CHK(convOn, 1'b0)
      wr(acr_pkg::ADDR_RESULT_HIGH, 8'h00FF);
      `CHK(rsp, acr_pkg::RESP_SLVERR)
      // Free running with divider code 2: restarts after the long first conversion
      wr(acr_pkg::ADDR_CONTROL_A, 8'hE2);
      repeat (120) @(posedge clk);
      rd(acr_pkg::ADDR_CONTROL_A);
      `CHK(dat, 8'hF2)
      `CHK(busy, 1'b1)
      finish_test();
   end
endmodule // tb_top
